/* cpd_pkg.sv */
`default_nettype none
package cpd_pkg;
    // Dictionary index bases for mapping and communication parameters
    localparam logic [15:0] TX_MAP_BASE = 16'h1a00;
    localparam logic [15:0] TX_MAP_LAST = 16'h1a1f;
    localparam logic [15:0] RX_MAP_BASE = 16'h1600;
    localparam logic [15:0] RX_MAP_LAST = 16'h161f;
    localparam logic [15:0] TX_COMM_BASE = 16'h1800;
    localparam logic [15:0] RX_COMM_BASE = 16'h1400;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_COB_ID = 8'h01;
    localparam logic [7:0] SUB_TX_TYPE = 8'h02;
    // Identifier value layout
    localparam int INVALID_BIT = 31;
    localparam logic [31:0] INVALID_FLAG = 32'h8000_0000;
    localparam logic [3:0] ENABLE_DIGIT_LIMIT = 4'h7;
    // Transmission types
    localparam logic [7:0] TT_EVENT = 8'hff;
    localparam logic [7:0] TT_STANDARD = 8'hff;
    // PDO numbering
    localparam int NUM_PDO = 32;
    localparam int NUM_STD = 4;
    localparam int LAST_VENDOR = 16;
    localparam int SER_PDO0 = 18;
    localparam int SER_PDO1 = 19;
    localparam int FIFO_DEPTH = 16;
    // Base identifiers by group of four PDOs, index by pdo-1
    localparam logic [10:0] TX_BASE [0:15] = '{
        11'h180, 11'h280, 11'h380, 11'h480,
        11'h1c0, 11'h2c0, 11'h3c0, 11'h4c0,
        11'h1e0, 11'h2e0, 11'h3e0, 11'h4e0,
        11'h1a0, 11'h2a0, 11'h3a0, 11'h4a0};
    localparam logic [10:0] RX_BASE [0:15] = '{
        11'h200, 11'h300, 11'h400, 11'h500,
        11'h240, 11'h340, 11'h440, 11'h540,
        11'h260, 11'h360, 11'h460, 11'h560,
        11'h220, 11'h320, 11'h420, 11'h520};
    // Mapping entry: object index, sub-index, bit length
    typedef struct packed {
        logic [15:0] index;
        logic [7:0] sub;
        logic [7:0] len;
    } cpd_map_t;
    // Dictionary access request and its answer
    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] data;
    } cpd_req_t;
    typedef struct packed {
        logic ok;
        logic [31:0] data;
    } cpd_rsp_t;
    localparam logic [15:0] OBJ_DIG_IN = 16'h6000;
    localparam logic [15:0] OBJ_DIG_OUT = 16'h6200;
    localparam logic [15:0] OBJ_ANA_IN = 16'h6401;
    localparam logic [15:0] OBJ_ANA_OUT = 16'h6411;
    localparam logic [15:0] OBJ_ENC_IN = 16'h6820;
    localparam logic [15:0] OBJ_ENC_OUT = 16'h5808;
    localparam logic [7:0] LEN_BYTE = 8'h08;
    localparam logic [7:0] LEN_WORD = 8'h10;
    localparam logic [7:0] LEN_DWORD = 8'h20;
endpackage : cpd_pkg
`default_nettype wire

/* cpd_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module cpd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : cpd_fifo
`default_nettype wire

/* cpd_defaults.sv */
`timescale 1ns/1ps
`default_nettype none
module cpd_defaults (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Station configuration
    input wire logic [6:0] node_id_in,
    input wire logic restore_in,
    input wire logic [7:0] dig_in_bytes_in,
    input wire logic [7:0] dig_out_bytes_in,
    input wire logic [4:0] ana_in_chans_in,
    input wire logic [4:0] ana_out_chans_in,
    input wire logic [3:0] enc_chans_in,
    // Dictionary access
    input wire logic req_valid_in,
    input wire cpd_pkg::cpd_req_t req_in,
    output logic rsp_valid_out,
    output cpd_pkg::cpd_rsp_t rsp_out,
    // Internal event for transmit PDOs
    input wire logic event_in,
    input wire logic [4:0] event_pdo_in,
    // Transmit requests to the CAN controller
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    output logic [10:0] tx_cob_out,
    // Status
    output logic loading_out
);
    ////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        CPD_IDLE = 2'b00,
        CPD_LOAD = 2'b01,
        CPD_RUN = 2'b10
    } cpd_state_t;

    cpd_state_t state;
    logic [4:0] load_idx;
    logic [6:0] node_lat;
    logic [31:0] tx_cob [0:31];
    logic [31:0] rx_cob [0:31];
    logic [7:0] tx_type [0:31];
    logic [6:0] tx_cnt [0:31];
    logic [6:0] rx_cnt [0:31];
    cpd_pkg::cpd_map_t tx_map [0:31][0:3];
    cpd_pkg::cpd_map_t rx_map [0:31][0:3];
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [10:0] fifo_out_data;
    logic ev_push;

    ////////////////////////////////////////////////////////////////////
    // Default identifier for PDO number idx+1
    function automatic logic [31:0] dflt_cob(input logic tx,
                                            input logic [4:0] idx,
                                            input logic [6:0] node);
        logic [31:0] v;
        v = cpd_pkg::INVALID_FLAG;
        if (idx < 5'(cpd_pkg::LAST_VENDOR)) begin
            v[10:0] = (tx ? cpd_pkg::TX_BASE[idx[3:0]] :
                       cpd_pkg::RX_BASE[idx[3:0]]) + {4'h0, node};
            if (idx < 5'(cpd_pkg::NUM_STD)) begin
                v[cpd_pkg::INVALID_BIT] = 1'b0;
            end
        end
        return v;
    endfunction : dflt_cob

    // Whether the station holds the objects a standard PDO needs
    function automatic logic std_exists(input logic tx,
                                        input logic [4:0] idx);
        logic r;
        r = 1'b0;
        if (idx == 5'h0) begin
            r = tx ? (dig_in_bytes_in != 8'h0) : (dig_out_bytes_in != 8'h0);
        end else if (idx < 5'(cpd_pkg::NUM_STD)) begin
            r = tx ? (ana_in_chans_in > {idx[2:0] - 3'h1, 2'b00})
                   : (ana_out_chans_in > {idx[2:0] - 3'h1, 2'b00});
        end
        return r;
    endfunction : std_exists

    // Preset mapping entry j for PDO idx+1
    function automatic cpd_pkg::cpd_map_t dflt_map(input logic tx,
                                                   input logic [4:0] idx,
                                                   input logic [1:0] j);
        cpd_pkg::cpd_map_t m;
        logic [1:0] grp;
        logic [1:0] pos;
        grp = idx[3:2];
        pos = idx[1:0];
        m = '0;
        if (idx == 5'h0 || grp == 2'h1) begin
            m.index = tx ? cpd_pkg::OBJ_DIG_IN : cpd_pkg::OBJ_DIG_OUT;
            m.sub = {3'h0, pos, j, 1'b0} + (idx == 5'h0 ? 8'h01 : 8'h09);
            m.len = cpd_pkg::LEN_BYTE;
        end else if (grp == 2'h2) begin
            m.index = tx ? cpd_pkg::OBJ_ENC_IN : cpd_pkg::OBJ_ENC_OUT;
            m.sub = {4'h0, pos, j[0]} + 8'h01;
            m.len = cpd_pkg::LEN_DWORD;
        end else begin
            m.index = tx ? cpd_pkg::OBJ_ANA_IN : cpd_pkg::OBJ_ANA_OUT;
            m.sub = {4'h0, pos, j}
                    + (grp == 2'h3 ? 8'h0d : 8'hfd);
            m.len = cpd_pkg::LEN_WORD;
        end
        return m;
    endfunction : dflt_map

    // Preset entry count; four entries max per PDO in this store
    function automatic logic [6:0] dflt_cnt(input logic tx,
                                            input logic [4:0] idx);
        logic [6:0] c;
        c = 7'h0;
        if (idx < 5'(cpd_pkg::NUM_STD)) begin
            c = std_exists(tx, idx) ? 7'h4 : 7'h0;
        end else if (idx < 5'(cpd_pkg::LAST_VENDOR)) begin
            c = (idx[3:2] == 2'h2) ? 7'h2 : 7'h4;
        end
        return c;
    endfunction : dflt_cnt

    ////////////////////////////////////////////////////////////////////
    // Default loader walks all 32 PDOs after reset or restore
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= CPD_IDLE;
            load_idx <= 5'h0;
            node_lat <= 7'h0;
        end else begin
            case (state)
                CPD_IDLE: begin
                    node_lat <= node_id_in;
                    load_idx <= 5'h0;
                    state <= CPD_LOAD;
                end
                CPD_LOAD: begin
                    load_idx <= load_idx + 5'h1;
                    if (load_idx == 5'h1f) begin
                        state <= CPD_RUN;
                    end
                end
                CPD_RUN: begin
                    if (restore_in) begin
                        state <= CPD_IDLE;
                    end
                end
                default: state <= CPD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Parameter store: loader writes defaults, dictionary writes after
    always_ff @(posedge clk_in) begin
        if (state == CPD_LOAD) begin
            tx_cob[load_idx] <= dflt_cob(1'b1, load_idx, node_lat);
            rx_cob[load_idx] <= dflt_cob(1'b0, load_idx, node_lat);
            tx_type[load_idx] <= (load_idx < 5'(cpd_pkg::NUM_STD))
                ? cpd_pkg::TT_STANDARD : cpd_pkg::TT_EVENT;
            tx_cnt[load_idx] <= dflt_cnt(1'b1, load_idx);
            rx_cnt[load_idx] <= dflt_cnt(1'b0, load_idx);
            for (int j = 0; j < 4; j++) begin
                tx_map[load_idx][j] <= dflt_map(1'b1, load_idx, 2'(j));
                rx_map[load_idx][j] <= dflt_map(1'b0, load_idx, 2'(j));
            end
            // Identifier marked invalid on a standard PDO whose objects are absent
            if (load_idx < 5'(cpd_pkg::NUM_STD) &&
                !std_exists(1'b1, load_idx)) begin
                tx_cob[load_idx][cpd_pkg::INVALID_BIT] <= 1'b1;
            end
            if (load_idx < 5'(cpd_pkg::NUM_STD) &&
                !std_exists(1'b0, load_idx)) begin
                rx_cob[load_idx][cpd_pkg::INVALID_BIT] <= 1'b1;
            end
        end else if (state == CPD_RUN && req_valid_in && req_in.write) begin
            if (req_in.index[15:5] == cpd_pkg::TX_COMM_BASE[15:5] &&
                req_in.sub == cpd_pkg::SUB_COB_ID) begin
                tx_cob[req_in.index[4:0]] <=
                    (req_in.data == 32'h0 &&
                     req_in.index[4:0] < 5'(cpd_pkg::NUM_STD))
                    ? dflt_cob(1'b1, req_in.index[4:0], node_lat)
                    : req_in.data;
            end
            if (req_in.index[15:5] == cpd_pkg::RX_COMM_BASE[15:5] &&
                req_in.sub == cpd_pkg::SUB_COB_ID) begin
                rx_cob[req_in.index[4:0]] <=
                    (req_in.data == 32'h0 &&
                     req_in.index[4:0] < 5'(cpd_pkg::NUM_STD))
                    ? dflt_cob(1'b0, req_in.index[4:0], node_lat)
                    : req_in.data;
            end
            if (req_in.index[15:5] == cpd_pkg::TX_COMM_BASE[15:5] &&
                req_in.sub == cpd_pkg::SUB_TX_TYPE) begin
                tx_type[req_in.index[4:0]] <= req_in.data[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Dictionary reads of identifiers, types and mappings
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rsp_valid_out <= 1'b0;
            rsp_out <= '0;
        end else begin
            rsp_valid_out <= req_valid_in && state == CPD_RUN;
            rsp_out <= '0;
            if (req_valid_in && !req_in.write) begin
                if (req_in.index[15:5] == cpd_pkg::TX_COMM_BASE[15:5]) begin
                    rsp_out.ok <= 1'b1;
                    rsp_out.data <= (req_in.sub == cpd_pkg::SUB_TX_TYPE)
                        ? {24'h0, tx_type[req_in.index[4:0]]}
                        : tx_cob[req_in.index[4:0]];
                end else if (req_in.index[15:5] ==
                             cpd_pkg::RX_COMM_BASE[15:5]) begin
                    rsp_out.ok <= 1'b1;
                    rsp_out.data <= rx_cob[req_in.index[4:0]];
                end else if (req_in.index >= cpd_pkg::TX_MAP_BASE &&
                             req_in.index <= cpd_pkg::TX_MAP_LAST) begin
                    rsp_out.ok <= 1'b1;
                    rsp_out.data <= (req_in.sub == cpd_pkg::SUB_COUNT)
                        ? {25'h0, tx_cnt[req_in.index[4:0]]}
                        : tx_map[req_in.index[4:0]][2'(req_in.sub - 8'h1)];
                end else if (req_in.index >= cpd_pkg::RX_MAP_BASE &&
                             req_in.index <= cpd_pkg::RX_MAP_LAST) begin
                    rsp_out.ok <= 1'b1;
                    rsp_out.data <= (req_in.sub == cpd_pkg::SUB_COUNT)
                        ? {25'h0, rx_cnt[req_in.index[4:0]]}
                        : rx_map[req_in.index[4:0]][2'(req_in.sub - 8'h1)];
                end
            end else if (req_valid_in) begin
                rsp_out.ok <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Enabled if leading digit below 7 and bit 31 clear
    assign ev_push = event_in && state == CPD_RUN
        && tx_cob[event_pdo_in][31:28] < cpd_pkg::ENABLE_DIGIT_LIMIT
        && !tx_cob[event_pdo_in][cpd_pkg::INVALID_BIT]
        && tx_type[event_pdo_in] == cpd_pkg::TT_EVENT;

    cpd_fifo #(
        .WIDTH(11),
        .DEPTH(cpd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(ev_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(tx_cob[event_pdo_in][10:0]),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(tx_ready_in && !tx_valid_out),
        .out_data_out(fifo_out_data)
    );

    // Registered transmit request; one entry in flight at a time
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_valid_out <= 1'b0;
            tx_cob_out <= 11'h0;
        end else if (tx_valid_out) begin
            tx_valid_out <= 1'b0;
        end else if (fifo_out_valid && tx_ready_in) begin
            tx_valid_out <= 1'b1;
            tx_cob_out <= fifo_out_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            loading_out <= 1'b1;
        end else begin
            loading_out <= (state != CPD_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_std_tx_id;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == CPD_LOAD && load_idx == 5'h0)
        |=> (tx_cob[0][10:0] == 11'h180 + {4'h0, node_lat}
             || tx_cob[0][31]);
    endproperty
    a_std_tx_id: assert property (p_std_tx_id) else $error("tpdo1 id");

    property p_rx_id;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == CPD_LOAD && load_idx == 5'h3)
        |=> rx_cob[3][10:0] == 11'h500 + {4'h0, node_lat};
    endproperty
    a_rx_id: assert property (p_rx_id) else $error("rpdo4 id");

    property p_vendor_invalid;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == CPD_LOAD && load_idx == 5'h4)
        |=> tx_cob[4][31] && rx_cob[4][31];
    endproperty
    a_vendor_invalid: assert property (p_vendor_invalid)
        else $error("vendor pdo valid");

    property p_tx13;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == CPD_LOAD && load_idx == 5'hc)
        |=> tx_cob[12] == (32'h8000_01a0 + {25'h0, node_lat});
    endproperty
    a_tx13: assert property (p_tx13) else $error("tpdo13 id");

    property p_serial;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == CPD_LOAD && load_idx == 5'h12)
        |=> tx_cob[17] == 32'h8000_0000 && rx_cob[17] == 32'h8000_0000
            && tx_cob[18] == 32'h8000_0000 && rx_cob[18] == 32'h8000_0000;
    endproperty
    a_serial: assert property (p_serial) else $error("serial id");

    property p_event_gate;
        @(posedge clk_in) disable iff (!rst_n_in)
        event_in && tx_cob[event_pdo_in][31] && !fifo_out_valid
        |=> !fifo_out_valid;
    endproperty
    a_event_gate: assert property (p_event_gate) else $error("invalid sent");

    property p_load_len;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(state == CPD_LOAD) |-> (state == CPD_LOAD) [*8];
    endproperty
    a_load_len: assert property (p_load_len) else $error("load short");

    property p_tx_pulse;
        @(posedge clk_in) disable iff (!rst_n_in)
        tx_valid_out |=> !tx_valid_out;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx not pulse");

    c_load_done: cover property (@(posedge clk_in) $rose(state == CPD_RUN));
    c_tx_sent: cover property (@(posedge clk_in) tx_valid_out);
    c_fifo_full: cover property (@(posedge clk_in) !fifo_in_ready);
endmodule : cpd_defaults
`default_nettype wire

/* cpd_can_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpd_can_model (
    // Clock
    input wire logic clk_in,
    // Transmit requests from the gateway
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic [10:0] tx_cob_in,
    // Test control and observation
    input wire logic stall_in,
    output logic [7:0] sent_out,
    output logic [10:0] last_cob_out
);
    logic [7:0] sent = 8'h00;
    logic [10:0] last_cob = 11'h000;
    assign sent_out = sent;
    assign last_cob_out = last_cob;
    ////////////////////////////////////////////////////////////////////////
    // Prompt or slow acceptance, held off while stalled
    always @(negedge clk_in) begin
        tx_ready_out <= !stall_in && ($urandom_range(3) != 0);
    end
    // Every pulse is a frame on the bus
    always @(posedge clk_in) begin
        if (tx_valid_in === 1'b1) begin
            sent <= sent + 8'h01;
            last_cob <= tx_cob_in;
        end
    end
endmodule : cpd_can_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [6:0] node = 7'h01;
    logic restore = 1'b0;
    logic [7:0] dib = 8'h00, dob = 8'h00;
    logic [4:0] aic = 5'h00, aoc = 5'h00;
    logic [3:0] enc = 4'h0;
    logic req_valid = 1'b0;
    cpd_pkg::cpd_req_t req = '0;
    cpd_pkg::cpd_rsp_t rsp, rd;
    logic rsp_valid, tx_valid, tx_ready, loading;
    logic ev = 1'b0;
    logic [4:0] ev_pdo = 5'h00;
    logic stall = 1'b1;
    logic [10:0] tx_cob, last_cob;
    logic [7:0] sent, s0;
    logic [3:0] dg [5] = '{4'h0, 4'h4, 4'h6, 4'h7, 4'h8};
    int err_total = 0;
    int checks_done = 0;

    initial begin
        forever #20 clk_in = ~clk_in;
    end

    cpd_defaults i_cpd_defaults (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .node_id_in(node), .restore_in(restore), .dig_in_bytes_in(dib),
        .dig_out_bytes_in(dob), .ana_in_chans_in(aic),
        .ana_out_chans_in(aoc), .enc_chans_in(enc),
        .req_valid_in(req_valid), .req_in(req), .rsp_valid_out(rsp_valid),
        .rsp_out(rsp), .event_in(ev), .event_pdo_in(ev_pdo),
        .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
        .tx_cob_out(tx_cob), .loading_out(loading));
    cpd_can_model i_cpd_can_model (.clk_in(clk_in),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .tx_cob_in(tx_cob), .stall_in(stall), .sent_out(sent),
        .last_cob_out(last_cob));

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic access(input logic w, input logic [15:0] idx,
                          input logic [7:0] sub, input logic [31:0] d);
        int n;
        @(negedge clk_in);
        req_valid = 1'b1;
        req = '{w, idx, sub, d};
        @(negedge clk_in);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 4) begin
            @(negedge clk_in);
            n++;
        end
        rd = rsp;
        chk("answer", 32'h1, 32'(rsp_valid));
    endtask : access

    task automatic fire(input logic [4:0] p, input logic on,
                        input logic [10:0] cob);
        int n;
        s0 = sent;
        @(negedge clk_in);
        ev = 1'b1;
        ev_pdo = p;
        @(negedge clk_in);
        ev = 1'b0;
        for (n = 0; n < 40 && sent == s0; n++) @(negedge clk_in);
        repeat (3) @(negedge clk_in);
        chk("frames", 32'(on), 32'(sent - s0));
        if (on) chk("cob", 32'(cob), 32'(last_cob));
    endtask : fire

    ////////////////////////////////////////////////////////////////////////
    // Expected identifier from group offset, slot and node number
    function automatic logic [31:0] exp_id(input logic tx, input int p);
        logic [10:0] off;
        case (p / 4)
            0: off = tx ? 11'h080 : 11'h000;
            1: off = tx ? 11'h0c0 : 11'h040;
            2: off = tx ? 11'h0e0 : 11'h060;
            default: off = tx ? 11'h0a0 : 11'h020;
        endcase
        if (p > 16) return 32'h8000_0000;
        return {p >= 4, 20'h0, off + 11'(((p % 4) + (tx ? 1 : 2)) * 256)
                + 11'(node)};
    endfunction : exp_id

    function automatic logic std_on(input logic tx, input int p);
        if (p == 0) return (tx ? dib : dob) != 8'h00;
        return (tx ? aic : aoc) > 5'(4 * (p - 1));
    endfunction : std_on

    task automatic scan();
        logic [31:0] e;
        logic on;
        for (int t = 0; t < 2; t++) begin
            for (int p = 0; p < 19; p++) begin
                if (p == 16) continue;
                e = exp_id(t[0], p);
                on = std_on(t[0], p);
                access(1'b0, (t ? 16'h1800 : 16'h1400) + 16'(p), 8'h01, 0);
                if (p < 4) begin
                    if (on) chk("std", e, rd.data);
                    else chk("flag", 32'h1, 32'(rd.data[31]));
                    access(1'b0, (t ? 16'h1a00 : 16'h1600) + 16'(p), 8'h00, 0);
                    chk("map", 32'(on), 32'(rd.data != 0));
                end else if (t == 1) begin
                    chk("tx", e, rd.data);
                    access(1'b0, 16'h1800 + 16'(p), 8'h02, 0);
                    if (p < 16) chk("type", 32'hff, rd.data & 32'hff);
                end else chk("rx", e, rd.data);
            end
        end
    endtask : scan

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        report_and_stop();
    end

    initial begin
        void'($urandom(86));
        for (int r = 0; r < 3; r++) begin
            @(negedge clk_in);
            node = 7'($urandom);
            {dib, dob, aic, aoc, enc} = 30'($urandom);
            if (r == 1) {dib, dob, aic, aoc} = 26'h0;
            if (r == 2) {node, dib, dob, aic, aoc} = 33'h1_ffff_ffff;
            if (r == 0) begin
                repeat (12) @(negedge clk_in);
                rst_n_in = 1'b1;
            end else begin
                restore = 1'b1;
                @(negedge clk_in);
                restore = 1'b0;
                for (int n = 0; n < 4 && loading !== 1'b1; n++)
                    @(negedge clk_in);
                chk("reload", 32'h1, 32'(loading));
            end
            for (int n = 0; n < 200 && loading !== 1'b0; n++)
                @(negedge clk_in);
            chk("loaded", 32'h0, 32'(loading));
            stall = 1'b0;
            scan();
        end
        foreach (dg[i]) begin
            access(1'b0, i[0] ? 16'h1a1f : 16'h161f, 8'h00, 0);
            chk("last map", 32'h1, 32'(rd.ok));
            access(1'b0, i[0] ? 16'h1a20 : 16'h1620, 8'h00, 0);
            chk("past map", 32'h0, 32'(rd.ok));
        end
        access(1'b1, 16'h1800, 8'h01, 32'h0000_0123);
        fire(5'h00, 1'b1, 11'h123);
        access(1'b1, 16'h1800, 8'h01, 32'h0);
        access(1'b0, 16'h1800, 8'h01, 32'h0);
        chk("restored", 32'h180 + 32'(node), rd.data);
        fire(5'h04, 1'b0, 11'h000);
        fire(5'h11, 1'b0, 11'h000);
        access(1'b1, 16'h1811, 8'h01, 32'h0000_0345);
        fire(5'h11, 1'b1, 11'h345);
        access(1'b1, 16'h1800, 8'h02, 32'h0);
        fire(5'h00, 1'b0, 11'h000);
        access(1'b1, 16'h1800, 8'h02, 32'hff);
        foreach (dg[i]) begin
            access(1'b1, 16'h1804, 8'h01,
                   {dg[i], 28'h1c0} + 32'(node));
            fire(5'h04, dg[i] < 4'h7, 11'h1c0 + 11'(node));
        end
        stall = 1'b1;
        repeat (3) @(negedge clk_in);
        s0 = sent;
        ev = 1'b1;
        ev_pdo = 5'h00;
        repeat (20) @(negedge clk_in);
        ev = 1'b0;
        repeat (4) @(negedge clk_in);
        chk("stalled", 32'(s0), 32'(sent));
        stall = 1'b0;
        repeat (200) @(negedge clk_in);
        chk("drained", 32'h10, 32'(sent - s0));
        chk("fifo cob", 32'h180 + 32'(node), 32'(last_cob));
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
